// ==== design/bdfa_top.sv ====
// Fault aggregation and error-pin logic of a four-transistor bridge driver.
// Assumes comparator outcomes arrive synchronous to aclk; registers over AXI4-Lite.
//
// Notes on behaviour
// - Gate-supply low: fault low, gate-supply error mode, gates actively off.
// - Gate-supply low clears itself on recovery, no enable pulse needed.
// - Overtemperature: fault low, gates keep running, normal mode with warning.
// - Overtemperature warning clears once comparator reports below threshold minus hysteresis.
// - Overcurrent flagged only after input held high for the filter time.
// - Overcurrent pulls fault low, gates stay on, warning only.
// - Overcurrent drops when signal falls or current commutates to high side.
// - Lockout or sleep: passive clamp while supply sense high, never drive on.
// - Enable low for minimum time clears latches; fault stays low meanwhile.
// - Fault releases high on next enable rising edge if nothing pending.
// - Short circuit stays latched, gates off, until an enable reset pulse.
// - Lockout switches gates, pump, regulator off; self clears, restarts with enable.
// - Supply lockout has priority level zero, the highest.
// - Short circuit and short-level open share priority level one.
// - Gate-supply low, overvoltage, overtemperature, overcurrent share level two.
// - Overvoltage held for its filter time: fault low, warning, self clearing.
// - Short-circuit detect latches the error at once, unfiltered, and switches all gates off.
// - Short-level open: gates actively off, fault set, clears when pin closes.
`timescale 1ns/10ps
module bdfa_top
   import bdfa_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // Host pins
   input  wire logic        chip_enable_pin,
   output logic            fault_n,
   // Comparator outcomes
   input  wire logic        gate_supply_low_cmp,
   input  wire logic        overtemp_cmp,
   input  wire logic        overcurrent_cmp,
   input  wire logic        low_side_conducting,
   input  wire logic        overvoltage_cmp,
   input  wire logic        supply_lockout_cmp,
   input  wire logic        short_circuit_det,
   input  wire logic        short_level_open_cmp,
   input  wire logic        supply_sense_high,
   // Driver control
   output logic            gates_enable,
   output logic            passive_clamp,
   output logic            pump_enable,
   output logic            regulator_enable,
   output logic [1:0]      fault_priority,
   output logic            irq,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0]  ADDR_STATUS  = 8'h00;
   localparam logic [7:0]  ADDR_EVENT   = 8'h04;
   localparam logic [7:0]  ADDR_MASK    = 8'h08;
   localparam logic [7:0]  ADDR_CTRL    = 8'h0c;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // One bit order for status, event, mask
   localparam int          NEV          = 7;
   localparam logic [6:0]  MASK_RESET   = 7'h00;

   // Enable-low counter, stops at the limit
   localparam int          RST_W        = 4;
   localparam logic [RST_W-1:0] RST_ONE = RST_W'(1);
   localparam logic [RST_W-1:0] RST_LIM = RST_W'(RST_LOW_CYC);

   // Event bits: 0 oc, 1 ov, 2 lockout, 3 vreg, 4 open, 5 short, 6 overtemp
   typedef struct packed {
      bdfa_mode_t       mode;
      logic             short_lat;
      logic             lockout_lat;
      logic             ena_prev;
      logic [RST_W-1:0] low_cnt;
      logic             cleared;
      logic             fault_n;
      logic             gates;
      logic [1:0]       prio;
      logic [NEV-1:0]   events;
      logic [NEV-1:0]   mask;
      logic             sw_force_off;
      logic             aw_done;
      logic             w_done;
      logic [7:0]       awaddr;
      logic [31:0]      wdata;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } bdfa_state_t;

   bdfa_state_t      st_q;
   bdfa_state_t      st_d;
   logic [NFILT-1:0] raw;
   logic [NFILT-1:0] filt;
   logic [NEV-1:0]   cond;
   logic             oc_now;
   logic             wr_fire;

   // ------------------------------------------------------------------
   // Comparator filters
   // ------------------------------------------------------------------
   assign raw[CH_OC]   = overcurrent_cmp & low_side_conducting;
   assign raw[CH_OV]   = overvoltage_cmp;
   assign raw[CH_UVLO] = supply_lockout_cmp;
   assign raw[CH_VREG] = gate_supply_low_cmp;
   assign raw[CH_SCOP] = short_level_open_cmp;

   generate
      for (genvar i = 0; i < NFILT; i++) begin : g_filt
         localparam int FC = (i == CH_OC)   ? OC_FILT_CYC   :
                             (i == CH_OV)   ? OV_FILT_CYC   :
                             (i == CH_UVLO) ? UVLO_FILT_CYC :
                             (i == CH_VREG) ? VREG_FILT_CYC : SCOP_FILT_CYC;
         bdfa_filter #(.FILT_CYC(FC)) u_filt (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .clk_en   (clk_en),
            .raw_in   (raw[i]),
            .filt_out (filt[i])
         );
      end
   endgenerate

   // Overcurrent falls as soon as the raw path falls, filter only delays the rise
   assign oc_now = filt[CH_OC] & raw[CH_OC];

   // Commit only once both halves are held
   assign wr_fire = st_q.aw_done & st_q.w_done & ~st_q.bvalid;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      logic any_err;
      logic ena_rise;
      logic [NEV-1:0] clr;
      any_err  = 1'b0;
      ena_rise = 1'b0;
      clr      = '0;
      st_d     = st_q;

      // Enable low phase: count, then clear latched errors
      ena_rise = chip_enable_pin & ~st_q.ena_prev;
      st_d.ena_prev = chip_enable_pin;
      if (!chip_enable_pin) begin
         if (st_q.low_cnt < RST_LIM) begin
            st_d.low_cnt = st_q.low_cnt + RST_ONE;
         end else begin
            st_d.short_lat   = 1'b0;
            st_d.lockout_lat = 1'b0;
            st_d.cleared     = 1'b1;
         end
      end else begin
         st_d.low_cnt = '0;
      end

      // Short latch persists until an enable reset pulse
      if (short_circuit_det) begin
         st_d.short_lat = 1'b1;
      end
      // Lockout remembered so restart waits for enable high
      if (filt[CH_UVLO]) begin
         st_d.lockout_lat = 1'b1;
      end else if (chip_enable_pin) begin
         st_d.lockout_lat = 1'b0;
      end

      // Live conditions, one per event bit
      cond[0] = oc_now;
      cond[1] = filt[CH_OV];
      cond[2] = filt[CH_UVLO] | st_q.lockout_lat;
      cond[3] = filt[CH_VREG];
      cond[4] = filt[CH_SCOP];
      cond[5] = st_q.short_lat;
      cond[6] = overtemp_cmp;
      any_err = |cond;

      // Mode and priority, level zero first
      if (cond[2]) begin
         st_d.mode = BDFA_LOCKOUT;
         st_d.prio = PRIO_LOCKOUT;
      end else if (cond[5]) begin
         st_d.mode = BDFA_SHORT_ERR;
         st_d.prio = PRIO_SHORT;
      end else if (cond[4]) begin
         st_d.mode = BDFA_OPEN_ERR;
         st_d.prio = PRIO_SHORT;
      end else if (cond[3]) begin
         st_d.mode = BDFA_VREG_ERR;
         st_d.prio = PRIO_WARN;
      end else if (cond[0] | cond[1] | cond[6]) begin
         st_d.mode = BDFA_WARNING;
         st_d.prio = PRIO_WARN;
      end else if (!chip_enable_pin) begin
         st_d.mode = BDFA_DISABLED;
         st_d.prio = PRIO_NONE;
      end else begin
         st_d.mode = BDFA_NORMAL;
         st_d.prio = PRIO_NONE;
      end

      // Gates run only in normal or warning mode
      case (st_d.mode)
         // Enable low is sleep: gates stay off
         BDFA_NORMAL, BDFA_WARNING: begin
            st_d.gates = ~st_q.sw_force_off & chip_enable_pin;
         end
         default:                   st_d.gates = 1'b0;
      endcase

      // Fault pin: low while any condition, during enable low, or until rising edge
      if (any_err || !chip_enable_pin) begin
         st_d.fault_n = 1'b0;
      end else if (st_q.cleared) begin
         if (ena_rise) begin
            st_d.fault_n = 1'b1;
            st_d.cleared = 1'b0;
         end
      end else begin
         st_d.fault_n = 1'b1;
      end

      // ----------------------------------------------------------------
      // AXI4-Lite slave
      // ----------------------------------------------------------------
      // Address and data may come in either order
      if (s_axi_awvalid && !st_q.aw_done) begin
         st_d.aw_done = 1'b1;
         st_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_done) begin
         st_d.w_done = 1'b1;
         st_d.wdata  = s_axi_wdata;
      end
      if (wr_fire) begin
         st_d.aw_done = 1'b0;
         st_d.w_done  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = RESP_OKAY;
         if (st_q.awaddr == ADDR_EVENT) begin
            clr = st_q.wdata[NEV-1:0];
         end else if (st_q.awaddr == ADDR_MASK) begin
            st_d.mask = st_q.wdata[NEV-1:0];
         end else if (st_q.awaddr == ADDR_CTRL) begin
            st_d.sw_force_off = st_q.wdata[0];
         end else if (st_q.awaddr != ADDR_STATUS) begin
            st_d.bresp = RESP_SLVERR;
         end
      end else if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      // Set beats clear when both land in one cycle
      st_d.events = (st_q.events & ~clr) | cond;

      // Read data holds until it is taken
      if (st_q.rvalid) begin
         if (s_axi_rready) begin
            st_d.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = RESP_OKAY;
         st_d.rdata  = '0;
         if (s_axi_araddr == ADDR_STATUS) begin
            // Status shows live conditions
            st_d.rdata = {17'h0, st_q.mode, 1'b0, st_q.prio, ~st_q.fault_n,
                          st_q.gates, cond};
         end else if (s_axi_araddr == ADDR_EVENT) begin
            st_d.rdata = {25'h0, st_q.events};
         end else if (s_axi_araddr == ADDR_MASK) begin
            st_d.rdata = {25'h0, st_q.mask};
         end else if (s_axi_araddr == ADDR_CTRL) begin
            st_d.rdata = {31'h0, st_q.sw_force_off};
         end else begin
            st_d.rresp = RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Fault low, mode disabled
         st_q         <= '0;
         st_q.mode    <= BDFA_DISABLED;
         st_q.prio    <= PRIO_NONE;
         st_q.mask    <= MASK_RESET;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign fault_n          = st_q.fault_n;
   assign gates_enable     = st_q.gates;
   // Clamp is passive: only while lockout/sleep and the supply can hold it
   assign passive_clamp    = (st_q.mode == BDFA_LOCKOUT || st_q.mode == BDFA_DISABLED)
                             & supply_sense_high;
   assign pump_enable      = (st_q.mode != BDFA_LOCKOUT) & chip_enable_pin;
   assign regulator_enable = (st_q.mode != BDFA_LOCKOUT);
   assign fault_priority   = st_q.prio;
   // Level output, drops on clear or mask
   assign irq              = |(st_q.events & st_q.mask);
   assign s_axi_awready    = ~st_q.aw_done;
   assign s_axi_wready     = ~st_q.w_done;
   assign s_axi_bvalid     = st_q.bvalid;
   assign s_axi_bresp      = st_q.bresp;
   assign s_axi_arready    = ~st_q.rvalid;
   assign s_axi_rvalid     = st_q.rvalid;
   assign s_axi_rdata      = st_q.rdata;
   assign s_axi_rresp      = st_q.rresp;

endmodule // bdfa_top

// ==== design/bdfa_pkg.sv ====
// Constants for the bridge driver fault aggregator.
// Assumes a 10 MHz aclk; all times are in ns and turned into cycle counts here.
package bdfa_pkg;

   // ------------------------------------------------------------------
   // Clock and filter times
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 100;
   localparam int OC_FILT_NS       = 2300;   // overcurrent filter, least time
   localparam int OV_FILT_NS       = 13000;  // overvoltage filter, least time
   localparam int UVLO_FILT_NS     = 20000;  // supply lockout filter
   localparam int VREG_FILT_NS     = 10000;  // gate-supply low filter, least time
   localparam int SCOP_FILT_NS     = 1500;   // short-level open filter, least time
   localparam int RST_LOW_NS       = 1200;   // enable low time that clears latches
   localparam int OC_FILT_CYC      = (OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OV_FILT_CYC      = (OV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UVLO_FILT_CYC    = (UVLO_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VREG_FILT_CYC    = (VREG_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCOP_FILT_CYC    = (SCOP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_LOW_CYC      = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int CNT_W            = 9;
   localparam int NFILT            = 5;

   // Filter channel indices
   localparam int CH_OC            = 0;
   localparam int CH_OV            = 1;
   localparam int CH_UVLO          = 2;
   localparam int CH_VREG          = 3;
   localparam int CH_SCOP          = 4;

   // ------------------------------------------------------------------
   // Priority levels and modes
   // ------------------------------------------------------------------
   localparam logic [1:0] PRIO_LOCKOUT = 2'h0;
   localparam logic [1:0] PRIO_SHORT   = 2'h1;
   localparam logic [1:0] PRIO_WARN    = 2'h2;
   localparam logic [1:0] PRIO_NONE    = 2'h3;

   typedef enum logic [2:0] {
      BDFA_NORMAL,
      BDFA_WARNING,
      BDFA_VREG_ERR,
      BDFA_SHORT_ERR,
      BDFA_OPEN_ERR,
      BDFA_LOCKOUT,
      BDFA_DISABLED
   } bdfa_mode_t;

endpackage

// ==== design/bdfa_filter.sv ====
// Digital persistence filter: output rises after the input stayed high
// for FILT_CYC cycles and falls on the first enabled edge after the input drops.
// Assumes a synchronous input and the shared clock enable.
`timescale 1ns/10ps
module bdfa_filter
   import bdfa_pkg::*;
#(
   parameter int FILT_CYC = 1
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic clk_en,
   // Comparator in, filtered out
   input  wire logic raw_in,
   output logic      filt_out
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             hit;
   } bdfa_filt_st_t;

   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(FILT_CYC - 1);

   bdfa_filt_st_t st_q;
   bdfa_filt_st_t st_d;

   always_comb begin
      st_d = st_q;
      if (!raw_in) begin
         st_d.cnt = '0;
         st_d.hit = 1'b0;
      end else if (st_q.cnt >= LIMIT) begin
         st_d.hit = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign filt_out = st_q.hit;

endmodule // bdfa_filter

// ==== testbench/bdfa_host.sv ====
// Host model: owns the enable pin and watches the fault pin.
// Assumes the fault pin is a push-pull level sampled on aclk.
`timescale 1ns/10ps
module bdfa_host
   import bdfa_pkg::*;
(
   // Clock
   input  wire logic aclk,
   // Pins
   input  wire logic fault_n,
   output logic      chip_enable_pin
);
   logic saw_high = 1'b0;
   int   low_cnt  = 0;

   initial chip_enable_pin = 1'b0;

   task automatic drive(input logic v);
      @(posedge aclk);
      chip_enable_pin <= v;
   endtask

   // A low phase below the clear time is legal but leaves latches set
   task automatic pulse(input int n);
      @(posedge aclk);
      chip_enable_pin <= 1'b0;
      repeat (n) @(posedge aclk);
      chip_enable_pin <= 1'b1;
   endtask

   // Fault must stay low through the low phase after its first three cycles
   always @(posedge aclk) begin
      low_cnt <= chip_enable_pin ? 0 : low_cnt + 1;
      if (low_cnt > 2 && fault_n) begin
         saw_high <= 1'b1;
      end
   end
endmodule // bdfa_host

// ==== testbench/bdfa_chk_sva.sv ====
// Checker: priority, gate and fault pin timing at the top ports.
// Assumes clk_en is held high, so filters run every edge.
`timescale 1ns/10ps
module bdfa_chk
   import bdfa_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Host pins
   input  wire logic       chip_enable_pin,
   input  wire logic       fault_n,
   // Comparators
   input  wire logic       overcurrent_cmp,
   input  wire logic       low_side_conducting,
   input  wire logic       supply_lockout_cmp,
   input  wire logic       short_circuit_det,
   input  wire logic       short_level_open_cmp,
   // Driver control
   input  wire logic       gates_enable,
   input  wire logic       passive_clamp,
   input  wire logic       pump_enable,
   input  wire logic       regulator_enable,
   input  wire logic [1:0] fault_priority
);
   // ------------------------------------------------------------------
   // Persistence counters, saturating so long faults never wrap
   // ------------------------------------------------------------------
   logic [7:0] lo_cnt;
   logic [7:0] oc_cnt;

   function automatic logic [7:0] nxt(input logic on, input logic [7:0] c);
      return !on ? 8'h00 : (c == 8'hff) ? c : c + 8'h01;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_cnt <= 8'h00;
         oc_cnt <= 8'h00;
      end else begin
         lo_cnt <= nxt(supply_lockout_cmp, lo_cnt);
         oc_cnt <= nxt(overcurrent_cmp && low_side_conducting, oc_cnt);
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_short_latch: assert property (
      short_circuit_det && !supply_lockout_cmp && fault_priority != PRIO_LOCKOUT
      |-> ##[1:3] (fault_priority == PRIO_SHORT && !gates_enable))
      else $error("short circuit not latched with gates off");
   a_short_hold: assert property (
      (chip_enable_pin && !short_level_open_cmp) [*6] ##0 fault_priority == PRIO_SHORT
      |=> !gates_enable)
      else $error("gates restarted while short latched");
   a_enable_low: assert property (!chip_enable_pin [*3] |-> !fault_n)
      else $error("fault released while enable low");
   a_prio_fault: assert property ((fault_priority != PRIO_NONE) [*3] |-> !fault_n)
      else $error("fault high while a condition is ranked");
   a_release_rise: assert property (
      $rose(fault_n) |-> chip_enable_pin && fault_priority == PRIO_NONE)
      else $error("fault released without enable or with condition");
   a_lockout_off: assert property (lo_cnt == 8'd205 |-> fault_priority == PRIO_LOCKOUT
      && !gates_enable && !pump_enable && !regulator_enable)
      else $error("lockout not ranked first or outputs still on");
   a_clamp_gates: assert property (passive_clamp |-> !gates_enable)
      else $error("gates driven while clamped");
   a_oc_warn: assert property (
      oc_cnt == 8'd30 |-> !fault_n && fault_priority != PRIO_NONE)
      else $error("held overcurrent not flagged");

   c_short: cover property (fault_priority == PRIO_SHORT && !gates_enable);
   c_lock: cover property (fault_priority == PRIO_LOCKOUT && passive_clamp);
   c_release: cover property ($rose(fault_n));
endmodule // bdfa_chk

bind bdfa_top bdfa_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .chip_enable_pin(chip_enable_pin), .fault_n(fault_n),
   .overcurrent_cmp(overcurrent_cmp), .low_side_conducting(low_side_conducting),
   .supply_lockout_cmp(supply_lockout_cmp), .short_circuit_det(short_circuit_det),
   .short_level_open_cmp(short_level_open_cmp), .gates_enable(gates_enable),
   .passive_clamp(passive_clamp), .pump_enable(pump_enable),
   .regulator_enable(regulator_enable), .fault_priority(fault_priority));

// ==== testbench/test_bridge_driver_fault_aggregator.sv ====
// Bench: drives comparator levels and the register bus, compares with a model.
// Assumes the host model owns the enable pin and the checker is bound to the top.
`timescale 1ns/10ps
module test_bridge_driver_fault_aggregator;
   import bdfa_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn, clk_en, gsl, ot, oc, ls, ov, lo, sc, op, ss, en, fault_n, irq;
   logic        awv, wv, br, arv, rr, awr, wr, bv, arr, rv, gates, clamp, pump, vreg;
   logic [7:0]  aw, ar;
   logic [31:0] wd, rd, rdata, rng, m_mask;
   logic [1:0]  prio, bresp, rresp, rs;
   int          mismatches = 0, tests_run = 0, cycles = 0, m_short = 0, n, i;
   int          fl[5];

   always #50 aclk = ~aclk;

   bdfa_host host (.aclk(aclk), .fault_n(fault_n), .chip_enable_pin(en));
   bdfa_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .chip_enable_pin(en),
      .fault_n(fault_n), .gate_supply_low_cmp(gsl), .overtemp_cmp(ot), .overcurrent_cmp(oc),
      .low_side_conducting(ls), .overvoltage_cmp(ov), .supply_lockout_cmp(lo),
      .short_circuit_det(sc), .short_level_open_cmp(op), .supply_sense_high(ss),
      .gates_enable(gates), .passive_clamp(clamp), .pump_enable(pump),
      .regulator_enable(vreg), .fault_priority(prio), .irq(irq), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

   // ------------------------------------------------------------------
   // Helpers and model
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic int exp_prio();
      if (lo) return 0;
      if (m_short != 0 || op) return 1;
      if (gsl || ot || ov || (oc && ls)) return 2;
      return 3;
   endfunction

   task automatic chk_state(input string nm);
      chk({nm, " prio"}, 32'(exp_prio()), 32'(prio));
      chk({nm, " gates"}, 32'(!(lo || m_short != 0 || op || gsl) && en), 32'(gates));
      chk({nm, " fault"}, 32'(exp_prio() == 3 && en), 32'(fault_n));
   endtask

   task automatic set_cond(input int k, input logic v);
      case (k)
         0: gsl <= v;
         1: ot <= v;
         2: {oc, ls} <= {v, v};
         3: ov <= v;
         default: op <= v;
      endcase
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {aw, wd, awv, wv, br} <= {a, d, 3'b111};
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      rs = bresp;
      br <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      {ar, arv, rr} <= {a, 2'b11};
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      {rd, rs} = {rdata, rresp};
      rr <= 1'b0;
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Whole run is near 800 cycles; the ceiling leaves wide margin
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      {aresetn, gsl, ot, oc, ls, ov, lo, sc, op, ss, awv, wv, br, arv, rr} = '0;
      {clk_en, aw, ar, wd, rng} = {1'b1, 16'h0, 32'h0, 32'd71};
      fl = '{VREG_FILT_CYC, 1, OC_FILT_CYC, OV_FILT_CYC, SCOP_FILT_CYC};
      cyc(10);
      chk("reset prio", 32'h3, 32'(prio));
      chk("reset fault", 32'h0, 32'(fault_n));
      chk("reset irq", 32'h0, 32'(irq));
      aresetn <= 1'b1;
      host.drive(1'b1);
      cyc(20);
      chk_state("idle");
      {clk_en, ot} <= 2'b01;
      cyc(4);
      chk("frozen fault", 32'h1, 32'(fault_n));
      {clk_en, ot} <= 2'b10;
      for (i = 0; i < 5; i++) begin
         set_cond(i, 1'b1);
         cyc(fl[i] + 8);
         chk_state("cond on");
         set_cond(i, 1'b0);
         cyc(8);
         chk_state("cond off");
      end
      // Overswing shorter than the filter must leave the pin alone
      n = 1 + int'(xs() % 32'(OC_FILT_CYC - 4));
      set_cond(2, 1'b1);
      for (i = 0; i < n + 6; i++) begin
         @(posedge aclk);
         if (i == n - 1) set_cond(2, 1'b0);
         chk("brief overcurrent", 32'h1, 32'(fault_n));
      end
      set_cond(2, 1'b1);
      cyc(OC_FILT_CYC + 8);
      ls <= 1'b0;
      cyc(6);
      chk_state("commutated");
      oc <= 1'b0;
      sc <= 1'b1;
      @(posedge aclk);
      sc <= 1'b0;
      m_short = 1;
      cyc(6);
      chk_state("short");
      host.pulse(5);
      cyc(6);
      chk_state("short brief low");
      ot <= 1'b1;
      cyc(4);
      chk_state("short overtemp");
      {ot, lo, ss} <= 3'b011;
      cyc(UVLO_FILT_CYC + 8);
      chk_state("lockout");
      chk("pump", 32'h0, 32'(pump));
      chk("regulator", 32'h0, 32'(vreg));
      chk("clamp on", 32'h1, 32'(clamp));
      ss <= 1'b0;
      cyc(2);
      chk("clamp off", 32'h0, 32'(clamp));
      lo <= 1'b0;
      cyc(8);
      chk("latched gates", 32'h0, 32'(gates));
      chk("latched fault", 32'h0, 32'(fault_n));
      host.pulse(RST_LOW_CYC + 2);
      m_short = 0;
      cyc(6);
      chk_state("cleared");
      chk("fault in low phase", 32'h0, 32'(host.saw_high));
      axi_write(8'h0c, 32'h1);
      cyc(2);
      chk("ctrl write", 32'h0, {29'h0, rs, gates});
      axi_write(8'h0c, 32'h0);
      cyc(2);
      chk_state("ctrl off");
      axi_write(8'h08, 32'h0);
      axi_write(8'h04, 32'h7f);
      axi_read(8'h04);
      chk("events", 32'h0, rd & 32'h7f);
      ot <= 1'b1;
      cyc(4);
      ot <= 1'b0;
      cyc(6);
      chk("irq masked", 32'h0, 32'(irq));
      axi_read(8'h04);
      chk("event overtemp", 32'h40, rd & 32'h7f);
      m_mask = xs() | 32'h40;
      axi_write(8'h08, m_mask);
      cyc(2);
      chk("irq", 32'h1, 32'(irq));
      axi_read(8'h08);
      chk("mask", m_mask & 32'h7f, rd & 32'h7f);
      axi_write(8'h04, 32'h40);
      cyc(2);
      chk("irq cleared", 32'h0, 32'(irq));
      axi_read(8'h00);
      chk("status prio", 32'h3, 32'(rd[10:9]));
      axi_read(8'h40);
      chk("unmapped resp", 32'h2, 32'(rs));
      chk("unmapped data", 32'h0, rd);
      give_verdict();
   end
endmodule // test_bridge_driver_fault_aggregator
